// ==== include/legacy_port_config_pkg.sv ====
package legacy_port_config_pkg;

   // ----------------------------------------------------------------
   // Configuration register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG = 8'h21;
   localparam logic [7:0] IDX_ECP_SOFTWARE_INDICATOR = 8'h22;
   localparam logic [7:0] IDX_LPT_BASE_ADDRESS = 8'h23;
   localparam logic [7:0] IDX_SERIAL_ONE_BASE_ADDRESS = 8'h24;
   localparam logic [7:0] IDX_SERIAL_TWO_BASE_ADDRESS = 8'h25;

   // One-hot register select, in index order
   localparam int NUM_CONFIG_REGS = 5;
   localparam int SEL_FLOPPY = 0;
   localparam int SEL_ECP = 1;
   localparam int SEL_LPT = 2;
   localparam int SEL_SERIAL_ONE = 3;
   localparam int SEL_SERIAL_TWO = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_CONFIG_INDEX = 8'h00;
   localparam logic [7:0] RESET_FLOPPY_REDIRECT_TIMEOUT_CONFIG = 8'h00;
   localparam logic [7:0] RESET_ECP_SOFTWARE_INDICATOR = 8'h00;
   localparam logic [7:0] RESET_LPT_BASE_ADDRESS = 8'h00;
   localparam logic [7:0] RESET_SERIAL_ONE_BASE_ADDRESS = 8'h00;
   localparam logic [7:0] RESET_SERIAL_TWO_BASE_ADDRESS = 8'h00;

   // ----------------------------------------------------------------
   // Field layouts
   // ----------------------------------------------------------------
   localparam int REDIRECT_LSB = 0;
   localparam int REDIRECT_MSB = 1;
   localparam int TIMEOUT_SELECT_BIT = 2;
   localparam logic [7:0] FLOPPY_CONFIG_WRITE_MASK = 8'h07;
   localparam int ECP_DMA_LSB = 0;
   localparam int ECP_DMA_MSB = 2;
   localparam int ECP_IRQ_LSB = 3;
   localparam int ECP_IRQ_MSB = 5;
   localparam logic [7:0] ECP_INDICATOR_WRITE_MASK = 8'h3F;
   localparam logic [7:0] LPT_BASE_WRITE_MASK = 8'hFF;
   localparam logic [7:0] SERIAL_BASE_WRITE_MASK = 8'hFE;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Floppy redirect field encodings
   localparam logic [1:0] REDIRECT_BY_PP_MODE = 2'b00;
   localparam logic [1:0] REDIRECT_DRIVE1_ONLY = 2'b01;
   localparam logic [1:0] REDIRECT_BOTH_DRIVES = 2'b10;
   localparam logic [1:0] REDIRECT_RESERVED = 2'b11;

   // ----------------------------------------------------------------
   // Address decode layout: base bit 0 lines up with I/O address bit 2
   // ----------------------------------------------------------------
   localparam int BASE_ADDR_LSB = 2;
   localparam int BASE_ADDR_MSB = 9;
   localparam int UPPER_ADDR_LSB = 10;
   localparam int UPPER_ADDR_MSB = 15;
   localparam int ECP_BANK_ADDR_BIT = 10;
   localparam int BASE_ADDR_BIT_EIGHT = 6;
   localparam int BASE_ADDR_BIT_NINE = 7;

endpackage

// ==== hw/port_addr_decode.sv ====
`timescale 1ns/1ns
// Combinational base address comparator shared by all three ports
module port_addr_decode
   import legacy_port_config_pkg::*;
(
   input wire logic [15:0] ioAddr,
   input wire logic [7:0] baseReg,
   input wire logic ignoreBitTwo,
   input wire logic allowBitTen,
   output logic selected
);

   logic portEnabled;
   logic upperOk;
   logic bitTwoOk;
   logic baseMatch;

   // ----------------------------------------------------------------
   // Enable and match terms
   // ----------------------------------------------------------------
   // A base with both top address bits clear switches the port off
   assign portEnabled = baseReg[BASE_ADDR_BIT_NINE] | baseReg[BASE_ADDR_BIT_EIGHT];

   // Upper bits must be zero; ECP mode lets bit 10 through for its high bank
   assign upperOk = allowBitTen
      ? (ioAddr[UPPER_ADDR_MSB:UPPER_ADDR_LSB+1] == 5'h0)
      : (ioAddr[UPPER_ADDR_MSB:UPPER_ADDR_LSB] == 6'h00);

   // Bit 2 compared only on 4-byte placement
   assign bitTwoOk = ignoreBitTwo | (ioAddr[BASE_ADDR_LSB] == baseReg[0]);

   assign baseMatch = (ioAddr[BASE_ADDR_MSB:BASE_ADDR_LSB+1] == baseReg[7:1]);

   assign selected = portEnabled & upperOk & bitTwoOk & baseMatch;

endmodule

// ==== hw/legacy_port_config_decode.sv ====
`timescale 1ns/1ns
module legacy_port_config_decode
   import legacy_port_config_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic configState,
   input wire logic cfgIndexWe,
   input wire logic cfgIndexRe,
   input wire logic cfgDataWe,
   input wire logic cfgDataRe,
   input wire logic [7:0] cfgWdata,
   output logic [7:0] cfgRdata,
   input wire logic floppyRedirectSelectN,
   input wire logic ppModeFloppyEnable,
   input wire logic ppModeDrive0OnParallel,
   input wire logic ppModeDrive1OnParallel,
   output logic floppyOnParallel,
   output logic drive0OnParallel,
   output logic drive1OnParallel,
   input wire logic eppTimeoutEvent,
   input wire logic eppStatusReadActive,
   input wire logic eppStatusWrite,
   input wire logic eppStatusWriteTimeoutBit,
   output logic eppTimeoutFlag,
   output logic [2:0] ecpDmaIndicator,
   output logic [2:0] ecpIrqIndicator,
   input wire logic [15:0] ioAddr,
   input wire logic eppEnabled,
   input wire logic ecpMode,
   output logic lptSelect,
   output logic serialOneSelect,
   output logic serialTwoSelect
);

   // ----------------------------------------------------------------
   // Index decode
   // ----------------------------------------------------------------
   // Shared by the write path and the read path so both agree on the map
   function automatic logic [NUM_CONFIG_REGS-1:0] decodeIndex(input logic [7:0] idx);
      logic [NUM_CONFIG_REGS-1:0] sel;
      sel = '0;
      case (idx)
         IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG: sel[SEL_FLOPPY] = 1'b1;
         IDX_ECP_SOFTWARE_INDICATOR: sel[SEL_ECP] = 1'b1;
         IDX_LPT_BASE_ADDRESS: sel[SEL_LPT] = 1'b1;
         IDX_SERIAL_ONE_BASE_ADDRESS: sel[SEL_SERIAL_ONE] = 1'b1;
         IDX_SERIAL_TWO_BASE_ADDRESS: sel[SEL_SERIAL_TWO] = 1'b1;
         default: sel = '0;
      endcase
      return sel;
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] configIndexRegister;
   logic [7:0] floppyRedirectTimeoutConfig;
   logic [7:0] ecpSoftwareIndicator;
   logic [7:0] lptBaseAddress;
   logic [7:0] serialOneBaseAddress;
   logic [7:0] serialTwoBaseAddress;
   logic [NUM_CONFIG_REGS-1:0] regSel;
   logic [NUM_CONFIG_REGS-1:0] regWrite;
   logic [7:0] next_cfgRdata;
   logic [1:0] redirectField;
   logic timeoutClearByWrite;
   logic statusReadPrev;
   logic statusReadTrailing;
   logic timeoutClear;
   logic lptHit;
   logic serialOneHit;
   logic serialTwoHit;
   logic next_floppyOnParallel;
   logic next_drive0OnParallel;
   logic next_drive1OnParallel;

   // Data port only does anything inside the configuration state
   assign regSel = decodeIndex(configIndexRegister);
   assign regWrite = (configState && cfgDataWe) ? regSel : '0;

   // ----------------------------------------------------------------
   // Index register
   // ----------------------------------------------------------------
   // Loaded only in configuration state; outside it the bank is sealed
   always_ff @(posedge clk) begin
      if (!nrst) begin
         configIndexRegister <= RESET_CONFIG_INDEX;
      end else if (configState && cfgIndexWe) begin
         configIndexRegister <= cfgWdata;
      end
   end

   // ----------------------------------------------------------------
   // Floppy redirect and timeout policy register
   // ----------------------------------------------------------------
   // Bits 7:3 are never stored, so they always read back zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         floppyRedirectTimeoutConfig <= RESET_FLOPPY_REDIRECT_TIMEOUT_CONFIG;
      end else if (regWrite[SEL_FLOPPY]) begin
         floppyRedirectTimeoutConfig <= cfgWdata & FLOPPY_CONFIG_WRITE_MASK;
      end
   end

   // ----------------------------------------------------------------
   // ECP software indicators
   // ----------------------------------------------------------------
   // Plain storage; nothing below reads these to route DMA or IRQ
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ecpSoftwareIndicator <= RESET_ECP_SOFTWARE_INDICATOR;
      end else if (regWrite[SEL_ECP]) begin
         ecpSoftwareIndicator <= cfgWdata & ECP_INDICATOR_WRITE_MASK;
      end
   end

   // Copies for the ECP config B readback path
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ecpDmaIndicator <= RESET_ECP_SOFTWARE_INDICATOR[ECP_DMA_MSB:ECP_DMA_LSB];
         ecpIrqIndicator <= RESET_ECP_SOFTWARE_INDICATOR[ECP_IRQ_MSB:ECP_IRQ_LSB];
      end else begin
         ecpDmaIndicator <= ecpSoftwareIndicator[ECP_DMA_MSB:ECP_DMA_LSB];
         ecpIrqIndicator <= ecpSoftwareIndicator[ECP_IRQ_MSB:ECP_IRQ_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Base address registers
   // ----------------------------------------------------------------
   // Parallel base: all eight bits are live comparator inputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lptBaseAddress <= RESET_LPT_BASE_ADDRESS;
      end else if (regWrite[SEL_LPT]) begin
         lptBaseAddress <= cfgWdata & LPT_BASE_WRITE_MASK;
      end
   end

   // Serial bases: bit 0 is forced low even if software forgets to clear it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         serialOneBaseAddress <= RESET_SERIAL_ONE_BASE_ADDRESS;
      end else if (regWrite[SEL_SERIAL_ONE]) begin
         serialOneBaseAddress <= cfgWdata & SERIAL_BASE_WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         serialTwoBaseAddress <= RESET_SERIAL_TWO_BASE_ADDRESS;
      end else if (regWrite[SEL_SERIAL_TWO]) begin
         serialTwoBaseAddress <= cfgWdata & SERIAL_BASE_WRITE_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unknown indices and reads outside configuration state return zero
   always_comb begin
      next_cfgRdata = READ_UNMAPPED;
      if (configState && cfgIndexRe) begin
         next_cfgRdata = configIndexRegister;
      end else if (configState && cfgDataRe) begin
         case (1'b1)
            regSel[SEL_FLOPPY]: next_cfgRdata = floppyRedirectTimeoutConfig;
            regSel[SEL_ECP]: next_cfgRdata = ecpSoftwareIndicator;
            regSel[SEL_LPT]: next_cfgRdata = lptBaseAddress;
            regSel[SEL_SERIAL_ONE]: next_cfgRdata = serialOneBaseAddress;
            regSel[SEL_SERIAL_TWO]: next_cfgRdata = serialTwoBaseAddress;
            default: next_cfgRdata = READ_UNMAPPED;
         endcase
      end
   end

   // Read data is held until the next read strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cfgRdata <= READ_UNMAPPED;
      end else if (cfgIndexRe || cfgDataRe) begin
         cfgRdata <= next_cfgRdata;
      end
   end

   // ----------------------------------------------------------------
   // Floppy redirection onto parallel pins
   // ----------------------------------------------------------------
   assign redirectField = floppyRedirectTimeoutConfig[REDIRECT_MSB:REDIRECT_LSB];

   // The pin acts only when low; a reserved code leaves everything native
   always_comb begin
      next_floppyOnParallel = 1'b0;
      next_drive0OnParallel = 1'b0;
      next_drive1OnParallel = 1'b0;
      case (redirectField)
         REDIRECT_BY_PP_MODE: begin
            next_floppyOnParallel = ppModeFloppyEnable;
            next_drive0OnParallel = ppModeDrive0OnParallel;
            next_drive1OnParallel = ppModeDrive1OnParallel;
         end
         REDIRECT_DRIVE1_ONLY: begin
            next_floppyOnParallel = !floppyRedirectSelectN;
            next_drive1OnParallel = !floppyRedirectSelectN;
         end
         REDIRECT_BOTH_DRIVES: begin
            next_floppyOnParallel = !floppyRedirectSelectN;
            next_drive0OnParallel = !floppyRedirectSelectN;
            next_drive1OnParallel = !floppyRedirectSelectN;
         end
         REDIRECT_RESERVED: begin
            next_floppyOnParallel = 1'b0;
         end
         default: begin
            next_floppyOnParallel = 1'b0;
         end
      endcase
   end

   // Registered so the pin muxes never see decode glitches
   always_ff @(posedge clk) begin
      if (!nrst) begin
         floppyOnParallel <= 1'b0;
         drive0OnParallel <= 1'b0;
         drive1OnParallel <= 1'b0;
      end else begin
         floppyOnParallel <= next_floppyOnParallel;
         drive0OnParallel <= next_drive0OnParallel;
         drive1OnParallel <= next_drive1OnParallel;
      end
   end

   // ----------------------------------------------------------------
   // EPP timeout flag
   // ----------------------------------------------------------------
   assign timeoutClearByWrite = floppyRedirectTimeoutConfig[TIMEOUT_SELECT_BIT];

   // Track the status read level to find its trailing edge
   always_ff @(posedge clk) begin
      if (!nrst) begin
         statusReadPrev <= 1'b0;
      end else begin
         statusReadPrev <= eppStatusReadActive;
      end
   end

   // Clearing at the trailing edge lets the read itself still see the flag
   assign statusReadTrailing = statusReadPrev && !eppStatusReadActive;
   assign timeoutClear = timeoutClearByWrite
      ? (eppStatusWrite && eppStatusWriteTimeoutBit)
      : statusReadTrailing;

   // A new timeout in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk) begin
      if (!nrst) begin
         eppTimeoutFlag <= 1'b0;
      end else if (eppTimeoutEvent) begin
         eppTimeoutFlag <= 1'b1;
      end else if (timeoutClear) begin
         eppTimeoutFlag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // I/O address decoders
   // ----------------------------------------------------------------
   // Parallel: 4-byte placement unless EPP needs eight ports
   port_addr_decode lptDecode (
      .ioAddr(ioAddr),
      .baseReg(lptBaseAddress),
      .ignoreBitTwo(eppEnabled),
      .allowBitTen(ecpMode),
      .selected(lptHit)
   );

   // Serial one: always 8-byte aligned, bit 10 must be zero
   port_addr_decode serialOneDecode (
      .ioAddr(ioAddr),
      .baseReg(serialOneBaseAddress),
      .ignoreBitTwo(1'b1),
      .allowBitTen(1'b0),
      .selected(serialOneHit)
   );

   // Serial two: same layout as serial one
   port_addr_decode serialTwoDecode (
      .ioAddr(ioAddr),
      .baseReg(serialTwoBaseAddress),
      .ignoreBitTwo(1'b1),
      .allowBitTen(1'b0),
      .selected(serialTwoHit)
   );

   // One cycle of latency; the function blocks must allow for it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lptSelect <= 1'b0;
         serialOneSelect <= 1'b0;
         serialTwoSelect <= 1'b0;
      end else begin
         lptSelect <= lptHit;
         serialOneSelect <= serialOneHit;
         serialTwoSelect <= serialTwoHit;
      end
   end

endmodule

// ==== verification/legacy_port_config_decode_asserts.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port-level checks for the configuration bank
// ----------------------------------------------------------------
module legacy_port_config_decode_asserts
   import legacy_port_config_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic configState,
   input wire logic cfgIndexWe,
   input wire logic cfgIndexRe,
   input wire logic cfgDataWe,
   input wire logic cfgDataRe,
   input wire logic [7:0] cfgWdata,
   input wire logic [7:0] cfgRdata,
   input wire logic floppyRedirectSelectN,
   input wire logic ppModeFloppyEnable,
   input wire logic ppModeDrive0OnParallel,
   input wire logic ppModeDrive1OnParallel,
   input wire logic floppyOnParallel,
   input wire logic drive0OnParallel,
   input wire logic drive1OnParallel,
   input wire logic eppTimeoutEvent,
   input wire logic eppStatusReadActive,
   input wire logic eppStatusWrite,
   input wire logic eppStatusWriteTimeoutBit,
   input wire logic eppTimeoutFlag,
   input wire logic [15:0] ioAddr,
   input wire logic eppEnabled,
   input wire logic ecpMode,
   input wire logic lptSelect,
   input wire logic serialOneSelect,
   input wire logic serialTwoSelect
);
   logic [7:0] idx;
   logic [2:0] flopCfg;
   logic [7:0] lptBase;
   logic expLpt;
   logic [2:0] expRedirect;
   logic writeClears;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // Shadow of software writes so the checks can follow register contents
   always_ff @(posedge clk) begin
      if (!nrst) begin
         idx <= 8'h00;
         flopCfg <= 3'h0;
         lptBase <= 8'h00;
      end else if (configState && cfgIndexWe) begin
         idx <= cfgWdata;
      end else if (configState && cfgDataWe && idx == IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG) begin
         flopCfg <= cfgWdata[2:0];
      end else if (configState && cfgDataWe && idx == IDX_LPT_BASE_ADDRESS) begin
         lptBase <= cfgWdata;
      end
   end

   // Expected parallel select and redirect outputs from current inputs
   always_comb begin
      expLpt = (lptBase[7:6] != 2'h0) && (ioAddr[15:11] == 5'h00) && (ecpMode || !ioAddr[10])
         && (ioAddr[9:3] == lptBase[7:1]) && (eppEnabled || ioAddr[2] == lptBase[0]);
      case (flopCfg[1:0])
         2'h0: expRedirect = {ppModeFloppyEnable, ppModeDrive0OnParallel, ppModeDrive1OnParallel};
         2'h1: expRedirect = {!floppyRedirectSelectN, 1'h0, !floppyRedirectSelectN};
         2'h2: expRedirect = {3{!floppyRedirectSelectN}};
         default: expRedirect = 3'h0;
      endcase
   end
   assign writeClears = eppStatusWrite && eppStatusWriteTimeoutBit && !eppTimeoutEvent;

   a_redirect_map: assert property ($past(nrst) |->
      {floppyOnParallel, drive0OnParallel, drive1OnParallel} == $past(expRedirect))
      else $error("redirect outputs disagree with field and pin");
   a_timeout_set: assert property (eppTimeoutEvent |=> eppTimeoutFlag)
      else $error("timeout flag not set by event");
   a_timeout_read_clear: assert property (!flopCfg[2] && $fell(eppStatusReadActive)
      && !eppTimeoutEvent |=> !eppTimeoutFlag) else $error("flag not cleared after read");
   a_timeout_write_clear: assert property (flopCfg[2] && writeClears |=> !eppTimeoutFlag)
      else $error("flag not cleared by written one");
   a_timeout_policy_hold: assert property (flopCfg[2] && eppTimeoutFlag && !eppTimeoutEvent
      && !writeClears |=> eppTimeoutFlag) else $error("flag lost without written one");
   a_lpt_decode_match: assert property ($past(nrst) |->
      lptSelect == $past(expLpt)) else $error("parallel select differs from base decode");
   a_serial_upper_bits: assert property (ioAddr[15:10] != 6'h00 |=>
      !serialOneSelect && !serialTwoSelect) else $error("serial select with high bits set");
   a_config_read_gate: assert property (!configState && (cfgDataRe || cfgIndexRe)
      |=> cfgRdata == 8'h00) else $error("read outside configuration state not zero");

   c_lpt_hit: cover property (lptSelect);
   c_both_drives: cover property (floppyOnParallel && drive0OnParallel && drive1OnParallel);
   c_flag_cleared: cover property ($fell(eppTimeoutFlag));
endmodule

bind legacy_port_config_decode legacy_port_config_decode_asserts legacy_port_config_decode_asserts_i (
   .clk, .nrst, .configState, .cfgIndexWe, .cfgIndexRe, .cfgDataWe, .cfgDataRe, .cfgWdata,
   .cfgRdata, .floppyRedirectSelectN, .ppModeFloppyEnable, .ppModeDrive0OnParallel,
   .ppModeDrive1OnParallel, .floppyOnParallel, .drive0OnParallel, .drive1OnParallel,
   .eppTimeoutEvent, .eppStatusReadActive, .eppStatusWrite, .eppStatusWriteTimeoutBit,
   .eppTimeoutFlag, .ioAddr, .eppEnabled, .ecpMode, .lptSelect, .serialOneSelect,
   .serialTwoSelect);

// ==== verification/legacy_port_config_decode_test.sv ====
`timescale 1ns/1ns
module legacy_port_config_decode_test
   import legacy_port_config_pkg::*;
   ;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic configState, cfgIndexWe, cfgIndexRe, cfgDataWe, cfgDataRe;
   logic [7:0] cfgWdata, cfgRdata, seen;
   logic floppyRedirectSelectN, ppModeFloppyEnable, ppModeDrive0OnParallel;
   logic ppModeDrive1OnParallel, floppyOnParallel, drive0OnParallel, drive1OnParallel;
   logic eppTimeoutEvent, eppStatusReadActive, eppStatusWrite, eppStatusWriteTimeoutBit;
   logic eppTimeoutFlag, eppEnabled, ecpMode, lptSelect, serialOneSelect, serialTwoSelect;
   logic [2:0] ecpDmaIndicator, ecpIrqIndicator, redir, sel;
   logic [15:0] ioAddr;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;

   assign redir = {floppyOnParallel, drive0OnParallel, drive1OnParallel};
   assign sel = {lptSelect, serialOneSelect, serialTwoSelect};

   // Half-period toggle gives the 4 ns clock
   always #2 clk = ~clk;

   legacy_port_config_decode legacy_port_config_decode_i (
      .clk, .nrst, .configState, .cfgIndexWe, .cfgIndexRe, .cfgDataWe, .cfgDataRe, .cfgWdata,
      .cfgRdata, .floppyRedirectSelectN, .ppModeFloppyEnable, .ppModeDrive0OnParallel,
      .ppModeDrive1OnParallel, .floppyOnParallel, .drive0OnParallel, .drive1OnParallel,
      .eppTimeoutEvent, .eppStatusReadActive, .eppStatusWrite, .eppStatusWriteTimeoutBit,
      .eppTimeoutFlag, .ecpDmaIndicator, .ecpIrqIndicator, .ioAddr, .eppEnabled, .ecpMode,
      .lptSelect, .serialOneSelect, .serialTwoSelect);

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic results();
      $display("Compares %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One strobe cycle; the read value is taken once the register has settled
   task automatic access(input logic isIdx, input logic isWr, input logic [7:0] d);
      @(posedge clk);
      cfgWdata <= d;
      cfgIndexWe <= isIdx && isWr;
      cfgDataWe <= !isIdx && isWr;
      cfgIndexRe <= isIdx && !isWr;
      cfgDataRe <= !isIdx && !isWr;
      @(posedge clk);
      {cfgIndexWe, cfgDataWe, cfgIndexRe, cfgDataRe} <= 4'h0;
      @(negedge clk);
      seen = cfgRdata;
   endtask

   task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
      access(1'h1, 1'h1, idx);
      access(1'h0, 1'h1, d);
   endtask

   task automatic rdReg(input logic [7:0] idx);
      access(1'h1, 1'h1, idx);
      access(1'h0, 1'h0, 8'h00);
   endtask

   // Flags are {eppEnabled, ecpMode, lpt, serial one, serial two}
   task automatic probe(input logic [15:0] a, input logic [4:0] f);
      @(posedge clk);
      ioAddr <= a;
      eppEnabled <= f[4];
      ecpMode <= f[3];
      repeat (2) @(negedge clk);
      check("port selects", {5'h00, sel}, {5'h00, f[2:0]});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_registers();
      logic [7:0] idxs[6] = '{IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG, IDX_ECP_SOFTWARE_INDICATOR,
         IDX_LPT_BASE_ADDRESS, IDX_SERIAL_ONE_BASE_ADDRESS, IDX_SERIAL_TWO_BASE_ADDRESS, 8'h30};
      logic [7:0] masks[6] = '{8'h07, 8'h3F, 8'hFF, 8'hFE, 8'hFE, 8'h00};
      for (int i = 0; i < 6; i++) begin
         rdReg(idxs[i]);
         check("reset value", seen, 8'h00);
         wrReg(idxs[i], 8'hFF);
         rdReg(idxs[i]);
         check("masked readback", seen, masks[i]);
      end
      wrReg(IDX_ECP_SOFTWARE_INDICATOR, 8'h2B);
      repeat (2) @(negedge clk);
      check("dma indicator", {5'h00, ecpDmaIndicator}, 8'h03);
      check("irq indicator", {5'h00, ecpIrqIndicator}, 8'h05);
   endtask

   // Writes and reads outside configuration state must leave no trace
   task automatic test_config_gate();
      wrReg(IDX_LPT_BASE_ADDRESS, 8'h5A);
      @(posedge clk);
      configState <= 1'h0;
      wrReg(IDX_ECP_SOFTWARE_INDICATOR, 8'hA5);
      access(1'h0, 1'h0, 8'h00);
      check("read outside state", seen, 8'h00);
      access(1'h1, 1'h0, 8'h00);
      check("index read outside state", seen, 8'h00);
      @(posedge clk);
      configState <= 1'h1;
      // The index must still point at the parallel base, the write above was sealed off
      access(1'h1, 1'h0, 8'h00);
      check("index kept", seen, IDX_LPT_BASE_ADDRESS);
      rdReg(IDX_LPT_BASE_ADDRESS);
      check("base kept", seen, 8'h5A);
   endtask

   // Mode inputs chosen so field 00 cannot be mistaken for any pin-driven case
   task automatic test_redirect();
      logic [2:0] expLow[4] = '{3'h2, 3'h5, 3'h7, 3'h0};
      logic [2:0] expHigh[4] = '{3'h2, 3'h0, 3'h0, 3'h0};
      logic [7:0] e;
      for (int f = 0; f < 4; f++) begin
         wrReg(IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG, 8'(f));
         for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            floppyRedirectSelectN <= p[0];
            repeat (2) @(negedge clk);
            e = {5'h00, p[0] ? expHigh[f] : expLow[f]};
            check("redirect", {5'h00, redir}, e);
         end
      end
   endtask

   task automatic test_timeout();
      for (int pol = 0; pol < 2; pol++) begin
         wrReg(IDX_FLOPPY_REDIRECT_TIMEOUT_CONFIG, {5'h00, pol[0], 2'h0});
         @(posedge clk);
         eppTimeoutEvent <= 1'h1;
         @(posedge clk);
         eppTimeoutEvent <= 1'h0;
         eppStatusReadActive <= 1'h1;
         repeat (2) @(posedge clk);
         eppStatusReadActive <= 1'h0;
         repeat (2) @(negedge clk);
         check("flag after read", {7'h00, eppTimeoutFlag}, {7'h00, pol[0]});
         for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            eppStatusWrite <= 1'h1;
            eppStatusWriteTimeoutBit <= b[0];
            @(posedge clk);
            eppStatusWrite <= 1'h0;
            @(negedge clk);
            check("flag after write", {7'h00, eppTimeoutFlag}, {7'h00, pol[0] && !b[0]});
         end
      end
   endtask

   // Bases 0x378, 0x3F8 and 0x2F8, then all three moved below 0x100
   task automatic test_decode();
      logic [15:0] addrs[11] = '{16'h037A, 16'h037C, 16'h037C, 16'h077A, 16'h077A, 16'h0B7A,
         16'h03FF, 16'h07F8, 16'h02FD, 16'h02F0, 16'h42F8};
      logic [4:0] flags[11] = '{5'h04, 5'h00, 5'h14, 5'h0C, 5'h00, 5'h08, 5'h02, 5'h00,
         5'h11, 5'h00, 5'h00};
      wrReg(IDX_LPT_BASE_ADDRESS, 8'hDE);
      wrReg(IDX_SERIAL_ONE_BASE_ADDRESS, 8'hFE);
      wrReg(IDX_SERIAL_TWO_BASE_ADDRESS, 8'hBE);
      for (int i = 0; i < 11; i++) begin
         probe(addrs[i], flags[i]);
      end
      wrReg(IDX_LPT_BASE_ADDRESS, 8'h1E);
      wrReg(IDX_SERIAL_ONE_BASE_ADDRESS, 8'h3E);
      wrReg(IDX_SERIAL_TWO_BASE_ADDRESS, 8'h20);
      probe(16'h0078, 5'h00);
      probe(16'h00F8, 5'h00);
      probe(16'h0080, 5'h00);
   endtask

   // Cycle ceiling well above the few hundred cycles the scenarios need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      {configState, cfgIndexWe, cfgIndexRe, cfgDataWe, cfgDataRe, cfgWdata} = 13'h0000;
      {ppModeFloppyEnable, ppModeDrive0OnParallel, ppModeDrive1OnParallel} = 3'h2;
      floppyRedirectSelectN = 1'h1;
      {eppTimeoutEvent, eppStatusReadActive, eppStatusWrite, eppStatusWriteTimeoutBit} = 4'h0;
      {ioAddr, eppEnabled, ecpMode} = 18'h0_0000;
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      configState <= 1'h1;
      test_registers();
      test_config_gate();
      test_redirect();
      test_timeout();
      test_decode();
      results();
   end
endmodule
